// ### verilog/hcm_pkg.sv
// constants, types and register map of the can transceiver mode control
//==============================================================
// Notes on behaviour
// - power-up starts in off mode, bus idle
// - off mode selectable in every chip mode
// - off mode ignores bus wake activity
// - normal mode only by command, chip normal
// - normal mode: low input drives dominant
// - no dominant until settling period elapsed
// - low held at settle end is suppressed
// - receive output low dominant, high recessive
// - path passes 5 Mbaud, order kept
// - receive-only mode offered for diagnostics
// - wake pattern in wake mode gives event
// - receive-only: driver off, receiver follows bus
// - after wake, receive output held low
// - mode field still reads wake code
package hcm_pkg;
    //==============================================================
    // clock and timing
    localparam int CLK_PERIOD_PS  = 4000;   // 250 mhz clock
    localparam int SETTLE_TIME_NS = 10000;  // enable_settle_time
    localparam int SETTLE_CYC     = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE1_TIME_NS  = 1000;   // least wake phase
    localparam int WAKE2_TIME_NS  = 16000;  // longest wake phase
    localparam int WAKE1_CYC      = (WAKE1_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE2_CYC      = (WAKE2_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int MAX_BAUD       = 5000000; // highest bit rate passed
    localparam int CNT_W          = 13;      // phase and settle counter width
    //==============================================================
    // register map, byte addresses
    localparam logic [7:0] ADR_CTRL  = 8'h00;
    localparam logic [7:0] ADR_STAT  = 8'h04;
    localparam logic [7:0] ADR_IRQST = 8'h08;
    localparam logic [7:0] ADR_IRQMK = 8'h0C;
    // ctrl field
    localparam int         MODE_LSB   = 0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    // status fields
    localparam int ST_SETTLED = 2;
    localparam int ST_ARMED   = 3;
    localparam int ST_WOKEN   = 4;
    localparam int ST_CHIPNRM = 5;
    // interrupt bits
    localparam int         IRQ_WAKE   = 0;
    localparam int         IRQ_READY  = 1;
    localparam int         IRQ_W      = 2;
    localparam logic [1:0] IRQ_RESET  = 2'h0;
    //==============================================================
    // transceiver modes
    typedef enum logic [1:0] {
        MODE_OFF    = 2'h0,
        MODE_WAKE   = 2'h1,
        MODE_RXONLY = 2'h2,
        MODE_NORMAL = 2'h3
    } hcm_mode_t;
    // wake pattern search states, one-hot
    typedef enum logic [3:0] {
        WK_DOM1 = 4'h1,
        WK_REC  = 4'h2,
        WK_DOM2 = 4'h4,
        WK_HIT  = 4'h8
    } hcm_wake_t;
endpackage : hcm_pkg

// ### verilog/hcm_phase.sv
// width qualifier for one bus level phase of the wake pattern
`timescale 1ns/10ps
module hcm_phase import hcm_pkg::*; (
    input  wire logic clk_i,   // system clock
    input  wire logic rst_i,   // sync reset
    input  wire logic clr_i,   // restart the measurement
    input  wire logic lvl_i,   // level being timed
    output logic      ok_o,    // phase ended inside window
    output logic      bad_o    // phase ended outside window
);
    logic [CNT_W-1:0] cnt;     // length of current phase
    logic             prev;    // level one cycle ago
    wire              ended   = prev & ~lvl_i;
    wire              in_win  = (cnt > CNT_W'(WAKE1_CYC)) && (cnt < CNT_W'(WAKE2_CYC));
    wire              at_max  = (cnt == CNT_W'(WAKE2_CYC));
    //==============================================================
    // count while the level lasts, saturate at the long limit
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt   <= '0;
            prev  <= 1'b0;
            ok_o  <= 1'b0;
            bad_o <= 1'b0;
        end else begin
            prev  <= lvl_i;
            ok_o  <= ended & in_win;
            bad_o <= ended & ~in_win;
            if (!lvl_i) begin
                cnt <= '0;
            end else if (!at_max) begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end
endmodule : hcm_phase

// ### verilog/hcm_ctrl.sv
// can transceiver mode control, tx/rx path, wake detection, wishbone regs
`timescale 1ns/10ps
module hcm_ctrl import hcm_pkg::*; (
    input  wire logic        clk_i,           // system clock
    input  wire logic        rst_i,           // sync reset, high
    // wishbone classic slave
    input  wire logic        cyc_i,           // bus cycle
    input  wire logic        stb_i,           // strobe
    input  wire logic        we_i,            // write enable
    input  wire logic [7:0]  adr_i,           // byte address
    input  wire logic [3:0]  sel_i,           // byte lanes
    input  wire logic [31:0] dat_i,           // write data
    output logic      [31:0] dat_o,           // read data
    output logic             ack_o,           // acknowledge
    // surrounding chip
    input  wire logic        chip_normal_i,   // chip in normal mode
    output logic             wake_event_o,    // one-cycle wake pulse
    output logic             irq_o,           // level interrupt
    // controller side
    input  wire logic        can_tx_input_i,  // low asks dominant
    output logic             can_rx_output_o, // low for dominant
    // bus side
    input  wire logic        bus_dom_i,       // receiver sees dominant
    output logic             bus_drive_o      // driver forces dominant
);
    //==============================================================
    // registers
    logic [1:0]       mode;        // software mode field
    logic [IRQ_W-1:0] irq_st;      // sticky events
    logic [IRQ_W-1:0] irq_mk;      // event mask
    logic [CNT_W-1:0] settle_cnt;  // enable settling timer
    logic             settled;     // settling period over
    logic             armed;       // recessive seen after settling
    logic             nrm_prev;    // normal active last cycle
    hcm_wake_t        wk_st;       // wake pattern search
    hcm_wake_t        next_wk_st;  // next search state
    logic [31:0]      next_dat;    // read mux result

    //==============================================================
    // bus decode
    wire bus_req  = cyc_i & stb_i;
    wire wr_go    = bus_req & we_i & ack_o & sel_i[0];
    wire wr_ctrl  = wr_go & (adr_i == ADR_CTRL);
    wire wr_irqst = wr_go & (adr_i == ADR_IRQST);
    wire wr_irqmk = wr_go & (adr_i == ADR_IRQMK);

    //==============================================================
    // effective modes
    wire nrm_on   = (mode == MODE_NORMAL) & chip_normal_i;
    wire rxo_on   = (mode == MODE_RXONLY);
    wire wake_on  = (mode == MODE_WAKE);
    wire nrm_new  = nrm_on & ~nrm_prev;
    wire settle_e = nrm_on & ~settled & (settle_cnt == CNT_W'(SETTLE_CYC - 1));
    wire woken    = (wk_st == WK_HIT);
    wire wake_hit = (next_wk_st == WK_HIT) & ~woken;

    //==============================================================
    // wake phase qualifiers, cleared outside wake mode
    logic dom_ok;  // dominant phase in window
    logic dom_bad; // dominant phase out of window
    logic rec_ok;  // recessive phase in window
    logic rec_bad; // recessive phase out of window

    hcm_phase u_dom (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .clr_i (~wake_on),
        .lvl_i (bus_dom_i),
        .ok_o  (dom_ok),
        .bad_o (dom_bad)
    );

    hcm_phase u_rec (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .clr_i (~wake_on),
        .lvl_i (~bus_dom_i),
        .ok_o  (rec_ok),
        .bad_o (rec_bad)
    );

    //==============================================================
    // mode field, reset selects off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= MODE_RESET;
        end else if (wr_ctrl) begin
            mode <= dat_i[MODE_LSB +: 2];
        end
    end

    //==============================================================
    // settling timer, restarts at each entry to normal
    always_ff @(posedge clk_i) begin
        if (rst_i || !nrm_on || nrm_new) begin
            settle_cnt <= '0;
            settled    <= 1'b0;
        end else if (settle_e) begin
            settled    <= 1'b1;
        end else if (!settled) begin
            settle_cnt <= settle_cnt + CNT_W'(1);
        end
    end

    // transmit arming: needs recessive after settling
    always_ff @(posedge clk_i) begin
        if (rst_i || !nrm_on) begin
            armed    <= 1'b0;
            nrm_prev <= 1'b0;
        end else begin
            nrm_prev <= 1'b1;
            if (settled && can_tx_input_i) begin
                armed <= 1'b1;
            end
        end
    end

    //==============================================================
    // wake search next state
    always_comb begin
        next_wk_st = wk_st;
        unique case (wk_st)
            WK_DOM1: if (dom_ok) next_wk_st = WK_REC;
            WK_REC: begin
                if (rec_ok) next_wk_st = WK_DOM2;
                else if (rec_bad) next_wk_st = WK_DOM1;
            end
            WK_DOM2: begin
                if (dom_ok) next_wk_st = WK_HIT;
                else if (dom_bad) next_wk_st = WK_DOM1;
            end
            WK_HIT: next_wk_st = WK_HIT;
            default: next_wk_st = WK_DOM1;
        endcase
    end

    // wake search, held idle outside wake mode
    always_ff @(posedge clk_i) begin
        if (rst_i || !wake_on) begin
            wk_st <= WK_DOM1;
        end else begin
            wk_st <= next_wk_st;
        end
    end

    //==============================================================
    // bus driver and receive output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_drive_o     <= 1'b0;
            can_rx_output_o <= 1'b1;
        end else begin
            // dominant only in settled, armed normal mode
            bus_drive_o <= nrm_on & settled & armed & ~can_tx_input_i;
            if (nrm_on || rxo_on) begin
                can_rx_output_o <= ~bus_dom_i;
            end else if (wake_on) begin
                can_rx_output_o <= ~(woken | wake_hit);
            end else begin
                can_rx_output_o <= 1'b1;
            end
        end
    end

    //==============================================================
    // interrupt status: set beats write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st       <= IRQ_RESET;
            irq_mk       <= IRQ_RESET;
            wake_event_o <= 1'b0;
            irq_o        <= 1'b0;
        end else begin
            wake_event_o <= wake_hit;
            if (wr_irqmk) begin
                irq_mk <= dat_i[IRQ_W-1:0];
            end
            irq_st[IRQ_WAKE]  <= wake_hit | (irq_st[IRQ_WAKE]
                                 & ~(wr_irqst & dat_i[IRQ_WAKE]));
            irq_st[IRQ_READY] <= settle_e | (irq_st[IRQ_READY]
                                 & ~(wr_irqst & dat_i[IRQ_READY]));
            irq_o <= |(irq_st & irq_mk);
        end
    end

    //==============================================================
    // read mux, unmapped reads zero
    always_comb begin
        next_dat = 32'h0000_0000;
        unique case (adr_i)
            ADR_CTRL:  next_dat[1:0] = mode;
            ADR_STAT: begin
                next_dat[1:0]        = nrm_on ? MODE_NORMAL
                                     : (mode == MODE_NORMAL ? MODE_OFF : mode);
                next_dat[ST_SETTLED] = settled;
                next_dat[ST_ARMED]   = armed;
                next_dat[ST_WOKEN]   = woken;
                next_dat[ST_CHIPNRM] = chip_normal_i;
            end
            ADR_IRQST: next_dat[IRQ_W-1:0] = irq_st;
            ADR_IRQMK: next_dat[IRQ_W-1:0] = irq_mk;
            default:   next_dat = 32'h0000_0000;
        endcase
    end

    // ack one cycle after request, dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req & ~ack_o;
            dat_o <= next_dat;
        end
    end

    //==============================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic past_rst; // first cycle after reset
    always_ff @(posedge clk_i) begin
        past_rst <= rst_i;
    end

    property p_reset_off;
        past_rst |-> (mode == MODE_OFF) && !bus_drive_o;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("not off after reset");

    property p_off_write;
        wr_ctrl && (dat_i[1:0] == MODE_OFF) |=> (mode == MODE_OFF);
    endproperty
    a_off_write: assert property (p_off_write) else $error("off not taken");

    property p_off_quiet;
        (mode == MODE_OFF) |=> !wake_event_o && !bus_drive_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("activity in off");

    property p_nrm_chip;
        bus_drive_o |-> $past(chip_normal_i) && ($past(mode) == MODE_NORMAL);
    endproperty
    a_nrm_chip: assert property (p_nrm_chip) else $error("drive outside normal");

    property p_tx_map;
        nrm_on && settled && armed && !can_tx_input_i |=> bus_drive_o;
    endproperty
    a_tx_map: assert property (p_tx_map) else $error("dominant not driven");

    property p_settle;
        nrm_new |=> !bus_drive_o [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("dominant while settling");

    property p_suppress;
        settle_e && !can_tx_input_i ##1 !can_tx_input_i |=> !bus_drive_o;
    endproperty
    a_suppress: assert property (p_suppress) else $error("held low not suppressed");

    property p_rx_follow;
        (nrm_on || rxo_on) |=> (can_rx_output_o == !$past(bus_dom_i));
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("rx not following");

    property p_rxonly;
        rxo_on |=> !bus_drive_o;
    endproperty
    a_rxonly: assert property (p_rxonly) else $error("driver on in rx only");

    property p_woken_low;
        woken && wake_on |=> !can_rx_output_o;
    endproperty
    a_woken_low: assert property (p_woken_low) else $error("rx not low after wake");

    property p_mode_keep;
        wake_hit && !wr_ctrl |=> (mode == MODE_WAKE);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode lost on wake");

    property p_restart;
        nrm_new |=> (settle_cnt == '0) && !settled;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    c_wake:   cover property (wake_event_o);
    c_ready:  cover property (settle_e ##[1:1000] bus_drive_o);
    c_rxonly: cover property (rxo_on && bus_dom_i ##1 !can_rx_output_o);
endmodule : hcm_ctrl

// ### verif/hcm_can_host.sv
// can controller model: drives the tx input, samples the rx output
`timescale 1ns/10ps
module hcm_can_host (
    input  wire logic clk_i,  // system clock
    input  wire logic rx_i,   // receive output of the block
    output logic      tx_o    // transmit input of the block
);
    logic [15:0] rx_seen;     // mid-bit samples, oldest first
    //==============================================================
    // idle recessive until a scenario asks otherwise
    initial begin
        tx_o    = 1'b1;
        rx_seen = 16'h0000;
    end
    // one level held for n cycles
    task automatic hold(input logic v, input int n);
        @(posedge clk_i);
        tx_o <= v;
        repeat (n - 1) @(posedge clk_i);
    endtask : hold
    // frame sent msb first, rx sampled in the middle of each bit
    task automatic send(input logic [15:0] bits, input int bit_cyc);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_i);
            tx_o <= bits[i];
            repeat (bit_cyc / 2) @(posedge clk_i);
            rx_seen = {rx_seen[14:0], rx_i};
            repeat (bit_cyc / 2 - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        tx_o <= 1'b1;
    endtask : send
endmodule : hcm_can_host

// ### verif/tb_hcm_ctrl.sv
// self-checking bench of the can transceiver mode control
`timescale 1ns/10ps
module tb_hcm_ctrl import hcm_pkg::*; ;
    logic        clk      = 1'b0;   // 250 mhz clock
    logic        rst      = 1'b1;   // sync reset
    logic        cyc      = 1'b0;   // bus cycle
    logic        stb      = 1'b0;   // strobe
    logic        we       = 1'b0;   // write enable
    logic [7:0]  adr      = 8'h00;  // byte address
    logic [3:0]  sel      = 4'h0;   // byte lanes
    logic [31:0] dat_w    = 32'h0;  // write data
    logic [31:0] dat_r;             // read data
    logic        ack;               // acknowledge
    logic        chip_nrm = 1'b0;   // chip in normal mode
    logic        ext_dom  = 1'b0;   // other node drives dominant
    logic        wake_ev;           // wake pulse
    logic        irq;               // level interrupt
    logic        tx;                // controller tx
    logic        rx;                // controller rx
    logic        drive;             // driver dominant
    wire         bus_dom  = drive | ext_dom;  // wired bus level
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          n_wake     = 0;    // wake pulses seen
    //==============================================================
    // clock and instances
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (wake_ev === 1'b1) n_wake <= n_wake + 1;
    end
    hcm_ctrl dut_u (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .chip_normal_i(chip_nrm), .wake_event_o(wake_ev), .irq_o(irq),
        .can_tx_input_i(tx), .can_rx_output_o(rx),
        .bus_dom_i(bus_dom), .bus_drive_o(drive)
    );
    hcm_can_host host_u (.clk_i(clk), .rx_i(rx), .tx_o(tx));
    //==============================================================
    // compare, verdict, bus cycles
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hF, q);
    endtask : rd
    // other node holds a bus level for n cycles
    task automatic lvl(input logic v, input int n);
        @(posedge clk);
        ext_dom <= v;
        repeat (n - 1) @(posedge clk);
    endtask : lvl
    // dominant, recessive, dominant phases inside the window
    task automatic wake_pat();
        lvl(1'b1, 400);
        lvl(1'b0, 400);
        lvl(1'b1, 400);
        lvl(1'b0, 20);
    endtask : wake_pat
    // waits for the settled interrupt, no dominant meanwhile
    task automatic settle();
        int n;
        int bad;
        n = 0;
        bad = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
            if (drive !== 1'b0) bad++;
        end
        // settled interrupt never came: count it and close the run
        if (irq !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
        chk("drive while settling", 32'(bad), 32'h0);
        chk("settle length", 32'(n >= SETTLE_CYC - 2 && n <= SETTLE_CYC + 4), 32'h1);
    endtask : settle
    //==============================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] q;
        chk("rx after reset", 32'(rx), 32'h1);
        chk("drive after reset", 32'(drive), 32'h0);
        rd(ADR_CTRL, q);
        chk("ctrl reset", q, 32'(MODE_RESET));
        wb(1'b1, ADR_CTRL, 32'h3, 4'h0, q);       // lane 0 off: ignored
        rd(ADR_CTRL, q);
        chk("ctrl lane", q, 32'h0);
        rd(8'h10, q);
        chk("unmapped read", q, 32'h0);
        wake_pat();
        chk("off wake pulses", 32'(n_wake), 32'h0);
        chk("off rx", 32'(rx), 32'h1);
    endtask : t_reset
    task automatic t_normal();
        logic [31:0] q;
        wr(ADR_CTRL, 32'h3);
        host_u.hold(1'b0, 20);
        chk("drive chip not normal", 32'(drive), 32'h0);
        rd(ADR_STAT, q);
        chk("stat mode", 32'(q[1:0]), 32'h0);
        wr(ADR_CTRL, 32'h0);
        rd(ADR_CTRL, q);
        chk("off select", q, 32'h0);
        wr(ADR_IRQST, 32'h3);
        wr(ADR_IRQMK, 32'h2);
        chip_nrm <= 1'b1;
        wr(ADR_CTRL, 32'h3);
        settle();
        repeat (10) @(posedge clk);
        chk("low across settle end", 32'(drive), 32'h0);
        host_u.hold(1'b1, 5);
        host_u.hold(1'b0, 5);
        chk("dominant request", 32'(drive), 32'h1);
        host_u.hold(1'b1, 5);
        chk("recessive request", 32'(drive), 32'h0);
        chk("irq settled", 32'(irq), 32'h1);
        wr(ADR_IRQST, 32'h2);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'(irq), 32'h0);
        host_u.send(16'hA5C3, 50);
        chk("looped frame", 32'(host_u.rx_seen), 32'h0000A5C3);
        wr(ADR_CTRL, 32'h0);
        wr(ADR_CTRL, 32'h3);
        settle();
        rd(ADR_STAT, q);
        chk("stat settled", q, 32'h0000002F);
    endtask : t_normal
    task automatic t_rxonly();
        wr(ADR_CTRL, 32'h2);
        host_u.hold(1'b0, 10);
        chk("rx only drive", 32'(drive), 32'h0);
        lvl(1'b1, 10);
        chk("rx only dominant", 32'(rx), 32'h0);
        lvl(1'b0, 10);
        chk("rx only recessive", 32'(rx), 32'h1);
        host_u.hold(1'b1, 2);
    endtask : t_rxonly
    task automatic t_wake();
        logic [31:0] q;
        int w0;
        wr(ADR_IRQST, 32'h3);
        wr(ADR_IRQMK, 32'h1);
        wr(ADR_CTRL, 32'h1);
        w0 = n_wake;
        wake_pat();
        chk("wake pulses", 32'(n_wake - w0), 32'h1);
        chk("wake irq", 32'(irq), 32'h1);
        repeat (50) @(posedge clk);
        chk("rx held low", 32'(rx), 32'h0);
        rd(ADR_CTRL, q);
        chk("ctrl after wake", q, 32'h1);
        rd(ADR_STAT, q);
        chk("stat woken", q, 32'h00000031);
        wr(ADR_IRQST, 32'h1);
        repeat (3) @(posedge clk);
        chk("wake irq cleared", 32'(irq), 32'h0);
        wr(ADR_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk("rx after leaving", 32'(rx), 32'h1);
        wr(ADR_CTRL, 32'h1);
        w0 = n_wake;
        wake_pat();
        chk("rearmed wake", 32'(n_wake - w0), 32'h1);
    endtask : t_wake
    //==============================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_normal();
        t_rxonly();
        t_wake();
        conclude();
    end
endmodule : tb_hcm_ctrl
